/* File: core/sfc_pkg.sv */
// constants and types shared by the serial flash framing ends
package sfc_pkg;
	localparam int ADDR_W = 21;
	localparam logic [20:0] TOP_ADDR = 21'h1FFFFF;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK_LSB = 16;
	localparam logic [8:0] LAST_SECTOR = 9'h1FF;
	localparam logic [4:0] LAST_BLOCK = 5'h1F;
	localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_ID_READ = 8'h9F;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_SMALL_UNIT_WIPE = 8'h20;
	localparam logic [7:0] OP_LARGE_UNIT_WIPE = 8'hD8;
	localparam logic [7:0] OP_CHIP_WIPE = 8'h60;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_POWER_DOWN_ENTER = 8'hB9;
	localparam logic [7:0] OP_POWER_DOWN_EXIT = 8'hAB;
	localparam logic [7:0] OP_MAKER_DEVICE_ID_READ = 8'h90;
	localparam logic [7:0] OP_LOCK_FLAGS_READ = 8'h2B;
	localparam logic [7:0] OP_LOCK_FLAGS_WRITE = 8'h2F;
	localparam logic [7:0] OP_OTP_WINDOW_ENTER = 8'hB1;
	localparam logic [7:0] OP_OTP_WINDOW_LEAVE = 8'hC1;
	localparam logic [7:0] ID_BYTE = 8'h5A; // arbitrary identity value
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int BUSY_CYCLES = 64;
	localparam int HALF_DIV = 4;
	typedef enum logic [2:0] {
		SFC_CLASS_BAD   = 3'h1,
		SFC_CLASS_READ  = 3'h2,
		SFC_CLASS_WRITE = 3'h4
	} sfc_class_e;
	// sorts an opcode into reads, writes or unknown
	function automatic sfc_class_e op_class(input logic [7:0] op);
		case (op)
			OP_ID_READ, OP_STATUS_READ, OP_READ, OP_FAST_READ, OP_MAKER_DEVICE_ID_READ,
			OP_LOCK_FLAGS_READ:
				op_class = SFC_CLASS_READ;
			OP_WRITE_LATCH_SET, OP_WRITE_LATCH_CLEAR, OP_STATUS_WRITE, OP_SMALL_UNIT_WIPE,
			OP_LARGE_UNIT_WIPE, OP_CHIP_WIPE, OP_PAGE_WRITE, OP_POWER_DOWN_ENTER,
			OP_POWER_DOWN_EXIT, OP_LOCK_FLAGS_WRITE, OP_OTP_WINDOW_ENTER, OP_OTP_WINDOW_LEAVE:
				op_class = SFC_CLASS_WRITE;
			default:
				op_class = SFC_CLASS_BAD;
		endcase
	endfunction
	function automatic logic [8:0] sector_of(input logic [20:0] a);
		sector_of = a[20:SECTOR_LSB];
	endfunction
	function automatic logic [4:0] block_of(input logic [20:0] a);
		block_of = a[20:BLOCK_LSB];
	endfunction
endpackage

/* File: core/sfc_link_if.sv */
// serial link between host controller and flash framing end
`timescale 1ns/1ns
`default_nettype none
interface sfc_link_if;
	logic sel_n;
	logic sclk;
	logic si;
	logic so_o;
	logic so_oe;
	// a released line reads high, as through a pull-up
	wire  so = so_oe ? so_o : 1'b1;
	modport dev  (input sel_n, input sclk, input si, output so_o, output so_oe);
	modport host (output sel_n, output sclk, output si, input so);
endinterface
`default_nettype wire

/* File: core/sfc_device.sv */
// flash end: command framing, address decode, busy guard
`timescale 1ns/1ns
`default_nettype none
module sfc_device
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	sfc_link_if.dev    link,
	output logic [7:0] last_op,
	output logic       op_done,
	output logic       op_rejected,
	output logic [8:0] sector_idx,
	output logic [4:0] block_idx,
	output logic       busy,
	output logic       active,
	output logic [7:0] status
);
	// ********
	// state
	// ********
	typedef enum logic [3:0] {
		SFC_DEV_IDLE    = 4'h1,
		SFC_DEV_OPCODE  = 4'h2,
		SFC_DEV_ACTIVE  = 4'h4,
		SFC_DEV_STANDBY = 4'h8
	} sfc_dev_e;
	typedef struct packed {
		logic [1:0]  sel_s;
		logic [1:0]  clk_s;
		logic [1:0]  si_s;
		logic        sel_q;
		logic        clk_q;
		sfc_dev_e    st;
		logic [2:0]  bitcnt;
		logic [7:0]  shin;
		logic [7:0]  op;
		sfc_pkg::sfc_class_e cls;
		logic [4:0]  bytes;
		logic [20:0] addr;
		logic [7:0]  shout;
		logic        out_en;
		// armed by out_en, pin driven only from the next falling edge
		logic        drv;
		logic        so;
		logic [7:0]  status;
		logic [7:0]  busy_cnt;
		logic [7:0]  last_op;
		logic        done;
		logic        rej;
		logic [8:0]  sector;
		logic [4:0]  block;
	} sfc_dev_s;
	sfc_dev_s s_reg;
	sfc_dev_s s_next;
	logic sel, sck, din, rise, fall, sel_fall, sel_rise;
	logic [7:0] byte_now;
	// ********
	// next state
	// ********
	// select, clock and data are pins: two flops each before any use
	always_comb
	begin
		sel      = s_reg.sel_s[1];
		sck      = s_reg.clk_s[1];
		din      = s_reg.si_s[1];
		rise     = sck & ~s_reg.clk_q & ~sel;
		fall     = ~sck & s_reg.clk_q & ~sel;
		sel_fall = ~sel & s_reg.sel_q;
		sel_rise = sel & ~s_reg.sel_q;
		byte_now = {s_reg.shin[6:0], din};
		s_next = s_reg;
		s_next.sel_s = {s_reg.sel_s[0], link.sel_n};
		s_next.clk_s = {s_reg.clk_s[0], link.sclk};
		s_next.si_s  = {s_reg.si_s[0], link.si};
		s_next.sel_q = sel;
		s_next.clk_q = sck;
		s_next.done  = 1'b0;
		s_next.rej   = 1'b0;
		// busy bit drops once the countdown is spent; a new set below wins
		if (s_reg.busy_cnt != 8'h00)
			s_next.busy_cnt = s_reg.busy_cnt - 8'h01;
		else
			s_next.status[0] = 1'b0;
		// mode 0 or 3: idle level is irrelevant, only edges while selected
		if (sel_fall)
		begin
			s_next.st     = SFC_DEV_OPCODE;
			s_next.bitcnt = 3'h0;
			s_next.bytes  = 5'h00;
			s_next.out_en = 1'b0;
			s_next.drv    = 1'b0;
		end
		else if (sel_rise)
		begin
			// cut or finished frame; writes run only on a whole byte while idle
			s_next.out_en = 1'b0;
			s_next.drv    = 1'b0;
			if (s_reg.st == SFC_DEV_ACTIVE && s_reg.cls == sfc_pkg::SFC_CLASS_WRITE)
			begin
				if (s_reg.bitcnt == 3'h0 && s_reg.status[0] == 1'b0)
				begin
					s_next.done    = 1'b1;
					s_next.last_op = s_reg.op;
					s_next.sector  = sfc_pkg::sector_of(s_reg.addr);
					s_next.block   = sfc_pkg::block_of(s_reg.addr);
					case (s_reg.op)
						sfc_pkg::OP_SMALL_UNIT_WIPE, sfc_pkg::OP_LARGE_UNIT_WIPE, sfc_pkg::OP_CHIP_WIPE,
						sfc_pkg::OP_PAGE_WRITE, sfc_pkg::OP_STATUS_WRITE:
						begin
							s_next.status[0] = 1'b1;
							s_next.busy_cnt  = 8'(sfc_pkg::BUSY_CYCLES);
						end
						sfc_pkg::OP_WRITE_LATCH_SET:   s_next.status[1] = 1'b1;
						sfc_pkg::OP_WRITE_LATCH_CLEAR: s_next.status[1] = 1'b0;
						default: ;
					endcase
				end
				else
					s_next.rej = 1'b1;
			end
			s_next.st = SFC_DEV_IDLE;
		end
		else if (rise)
		begin
			s_next.shin   = byte_now;
			s_next.bitcnt = s_reg.bitcnt + 3'h1;
			case (s_reg.st)
				SFC_DEV_OPCODE:
					if (s_reg.bitcnt == 3'h7)
					begin
						s_next.op  = byte_now;
						s_next.cls = sfc_pkg::op_class(byte_now);
						s_next.bytes = 5'h01;
						s_next.addr  = 21'h000000;
						// unknown opcode: no output and no action until the next frame
						if (sfc_pkg::op_class(byte_now) == sfc_pkg::SFC_CLASS_BAD)
							s_next.st = SFC_DEV_STANDBY;
						else
						begin
							s_next.st = SFC_DEV_ACTIVE;
							if (byte_now == sfc_pkg::OP_STATUS_READ)
							begin
								s_next.shout  = s_reg.status;
								s_next.out_en = 1'b1;
							end
							else if (byte_now == sfc_pkg::OP_ID_READ)
							begin
								s_next.shout  = sfc_pkg::ID_BYTE;
								s_next.out_en = 1'b1;
							end
						end
					end
				SFC_DEV_ACTIVE:
					if (s_reg.bitcnt == 3'h7 && s_reg.bytes < 5'h04)
					begin
						// address bytes come MSB first; bits above the top address drop out
						s_next.bytes = s_reg.bytes + 5'h01;
						s_next.addr  = {s_reg.addr[12:0], byte_now} & sfc_pkg::TOP_ADDR;
						// array data is not modelled; reads return the address low byte
						if (s_reg.bytes == 5'h03 && s_reg.cls == sfc_pkg::SFC_CLASS_READ
							&& s_reg.op != sfc_pkg::OP_STATUS_READ && s_reg.op != sfc_pkg::OP_ID_READ)
						begin
							s_next.shout  = byte_now;
							s_next.out_en = ~s_reg.status[0];
						end
					end
					else if (s_reg.bitcnt == 3'h7 && s_reg.op == sfc_pkg::OP_STATUS_READ)
						s_next.shout = s_reg.status;
				default: ;
			endcase
		end
		else if (fall && s_reg.out_en && s_reg.st == SFC_DEV_ACTIVE)
		begin
			s_next.so    = s_reg.shout[7];
			s_next.drv   = 1'b1;
			s_next.shout = {s_reg.shout[6:0], s_reg.shout[7]};
		end
	end
	// ********
	// state register
	// ********
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_reg <= '{sel_s: 2'h3, clk_s: 2'h0, si_s: 2'h0, sel_q: 1'b1, clk_q: 1'b0,
				st: SFC_DEV_IDLE, cls: sfc_pkg::SFC_CLASS_BAD, status: sfc_pkg::STATUS_RESET,
				default: '0};
		end
		else
			s_reg <= s_next;
	end
	// ********
	// outputs
	// ********
	// output only while selected and active; standby stays undriven
	// enabling at a falling edge keeps a stale bit off the pin in the high phase
	assign link.so_o    = s_reg.so;
	assign link.so_oe   = s_reg.drv && s_reg.st == SFC_DEV_ACTIVE && !sel;
	assign last_op      = s_reg.last_op;
	assign op_done      = s_reg.done;
	assign op_rejected  = s_reg.rej;
	assign sector_idx   = s_reg.sector;
	assign block_idx    = s_reg.block;
	assign busy         = s_reg.status[0];
	assign active       = s_reg.st == SFC_DEV_ACTIVE;
	assign status       = s_reg.status;
endmodule
`default_nettype wire

/* File: core/sfc_host.sv */
// host end: drives select and clock, shifts bytes in and out
`timescale 1ns/1ns
`default_nettype none
module sfc_host
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	sfc_link_if.host        link,
	input  wire logic       start,
	input  wire logic [7:0] tx_byte,
	input  wire logic [5:0] nbits,
	input  wire logic       clock_idle_polarity,
	output logic            ready,
	output logic [7:0]      rx_byte,
	output logic            done
);
	typedef enum logic [2:0] {
		SFC_HOST_IDLE = 3'h1,
		SFC_HOST_LOW  = 3'h2,
		SFC_HOST_HIGH = 3'h4
	} sfc_host_e;
	typedef struct packed {
		logic [1:0] so_s;
		sfc_host_e  st;
		logic [2:0] div;
		logic [5:0] left;
		logic [7:0] tx;
		logic [7:0] rx;
		logic       sel_n;
		logic       sck;
		logic       si;
		logic       done;
	} sfc_host_s;
	sfc_host_s h_reg;
	sfc_host_s h_next;
	always_comb
	begin
		h_next = h_reg;
		h_next.so_s = {h_reg.so_s[0], link.so};
		h_next.done = 1'b0;
		h_next.div  = h_reg.div + 3'h1;
		case (h_reg.st)
			SFC_HOST_IDLE:
			begin
				h_next.sck   = clock_idle_polarity;
				h_next.sel_n = 1'b1;
				if (start && nbits != 6'h00)
				begin
					h_next.sel_n = 1'b0;
					h_next.tx    = tx_byte;
					h_next.si    = tx_byte[7];
					h_next.left  = nbits;
					h_next.div   = 3'h0;
					h_next.sck   = 1'b0;
					h_next.st    = SFC_HOST_LOW;
				end
			end
			SFC_HOST_LOW:
				if (h_reg.div == 3'(sfc_pkg::HALF_DIV - 1))
				begin
					h_next.sck = 1'b1;
					h_next.div = 3'h0;
					h_next.tx  = {h_reg.tx[6:0], 1'b0};
					h_next.left = h_reg.left - 6'h01;
					h_next.st  = SFC_HOST_HIGH;
				end
			SFC_HOST_HIGH:
			begin
				// the pin reaches so_s[1] one edge after the rise, so take the bit then
				if (h_reg.div == 3'h1)
					h_next.rx = {h_reg.rx[6:0], h_reg.so_s[1]};
				if (h_reg.div == 3'(sfc_pkg::HALF_DIV - 1))
				begin
					h_next.div = 3'h0;
					if (h_reg.left == 6'h00)
					begin
						// any bit count ends a read; writes need a multiple of eight
						h_next.sel_n = 1'b1;
						h_next.sck   = clock_idle_polarity;
						h_next.done  = 1'b1;
						h_next.st    = SFC_HOST_IDLE;
					end
					else
					begin
						h_next.sck = 1'b0;
						h_next.si  = h_reg.tx[7];
						h_next.st  = SFC_HOST_LOW;
					end
				end
			end
			default:
				h_next.st = SFC_HOST_IDLE;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			h_reg <= '{st: SFC_HOST_IDLE, sel_n: 1'b1, default: '0};
		else
			h_reg <= h_next;
	end
	assign link.sel_n = h_reg.sel_n;
	assign link.sclk  = h_reg.sck;
	assign link.si    = h_reg.si;
	assign ready      = h_reg.st == SFC_HOST_IDLE;
	assign rx_byte    = h_reg.rx;
	assign done       = h_reg.done;
endmodule
`default_nettype wire

/* File: bench/sfc_link_chk.sv */
// link timing assertions for the serial flash framing ends
`timescale 1ns/1ns
`default_nettype none
module sfc_link_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic si,
	input wire logic so_o,
	input wire logic so_oe
);
	// ********
	// wire rules
	// ********
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence high_phase;
		sclk [*4];
	endsequence
	sequence low_phase;
		!sclk [*4];
	endsequence
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> high_phase)
		else $error("clock high phase too short");
	AST_SCLK_LOW: assert property ($fell(sclk) |-> low_phase)
		else $error("clock low phase too short");
	AST_SI_AT_RISE: assert property ($rose(sclk) |-> $stable(si) ##1 $stable(si))
		else $error("input bit moved at rising clock");
	AST_SO_MOVES_LOW: assert property (so_oe && $changed(so_o) |-> !sclk)
		else $error("output bit moved while clock high");
	AST_OE_IDLE: assert property (sel_n [*4] |-> !so_oe)
		else $error("output driven while deselected");
	AST_OE_SELECTED: assert property ($rose(so_oe) |-> !sel_n && !sclk)
		else $error("output enabled outside a frame");
	AST_OE_RELEASE: assert property ($rose(sel_n) |-> ##[1:4] !so_oe)
		else $error("output held after select rose");
	// a fresh frame starts with the output undriven, whatever came before
	AST_OE_FRESH: assert property ($fell(sel_n) |-> !so_oe [*8])
		else $error("output driven before opcode complete");
endmodule
`default_nettype wire

/* File: bench/serial_flash_cmd_framing_test.sv */
// self-checking bench joining host and flash framing ends
`timescale 1ns/1ns
`default_nettype none
module serial_flash_cmd_framing_test;
	logic       clk;
	logic       rst_n;
	logic       start;
	logic [7:0] tx_byte;
	logic [5:0] nbits;
	logic       clock_idle_polarity;
	logic       ready;
	logic [7:0] rx_byte;
	logic       done;
	logic [7:0] last_op;
	logic       op_done;
	logic       op_rejected;
	logic [8:0] sector_idx;
	logic [4:0] block_idx;
	logic       busy;
	logic       active;
	logic [7:0] status;
	logic       seen_done;
	logic       seen_rej;
	logic       seen_act;
	int         n_mismatch;
	int         comparisons;
	sfc_link_if i_sfc_link_if ();
	sfc_host i_sfc_host (.clk(clk), .rst_n(rst_n), .link(i_sfc_link_if.host), .start(start), .tx_byte(tx_byte),
		.nbits(nbits), .clock_idle_polarity(clock_idle_polarity), .ready(ready), .rx_byte(rx_byte), .done(done));
	sfc_device i_sfc_device (.clk(clk), .rst_n(rst_n), .link(i_sfc_link_if.dev), .last_op(last_op),
		.op_done(op_done), .op_rejected(op_rejected), .sector_idx(sector_idx), .block_idx(block_idx),
		.busy(busy), .active(active), .status(status));
	sfc_link_chk i_sfc_link_chk (.clk(clk), .rst_n(rst_n), .sel_n(i_sfc_link_if.sel_n),
		.sclk(i_sfc_link_if.sclk), .si(i_sfc_link_if.si), .so_o(i_sfc_link_if.so_o), .so_oe(i_sfc_link_if.so_oe));
	// ********
	// clock, monitors, tasks
	// ********
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (op_done) seen_done <= 1'b1;
		if (op_rejected) seen_rej <= 1'b1;
		if (active) seen_act <= 1'b1;
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic [7:0] op, input logic [5:0] n);
		int i;
		i = 0;
		while (ready !== 1'b1 && i < 100)
		begin
			@(posedge clk);
			#1 i++;
		end
		if (i == 100)
		begin
			n_mismatch++;
			final_report();
		end
		start = 1'b1;
		tx_byte = op;
		nbits = n;
		seen_done = 1'b0;
		seen_rej = 1'b0;
		seen_act = 1'b0;
		@(posedge clk);
		#1 start = 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 600)
		begin
			@(posedge clk);
			#1 i++;
		end
		if (i == 600)
		begin
			n_mismatch++;
			final_report();
		end
		// select is resynchronised, so let the device settle
		repeat (8) @(posedge clk);
		#1;
	endtask
	// ********
	// scenarios
	// ********
	initial
	begin
		int i;
		rst_n = 1'b0;
		start = 1'b0;
		tx_byte = 8'h00;
		nbits = 6'h08;
		clock_idle_polarity = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		// let the idle clock level settle before the first frame
		repeat (4) @(posedge clk);
		#1;
		xfer(sfc_pkg::OP_WRITE_LATCH_SET, 6'h08);
		check("latch done", 9'h001, seen_done);
		check("last op", sfc_pkg::OP_WRITE_LATCH_SET, last_op);
		check("latch bit", 9'h001, status[1]);
		xfer(sfc_pkg::OP_WRITE_LATCH_CLEAR, 6'h09);
		check("odd reject", 9'h001, seen_rej);
		check("odd latch", 9'h001, status[1]);
		xfer(sfc_pkg::OP_ID_READ, 6'h10);
		check("id data", sfc_pkg::ID_BYTE, rx_byte);
		check("id active", 9'h001, seen_act);
		check("id after", 9'h000, active);
		xfer(sfc_pkg::OP_STATUS_READ, 6'h0D);
		check("cut active", 9'h000, active);
		xfer(sfc_pkg::OP_STATUS_READ, 6'h10);
		check("status data", 9'h002, rx_byte);
		xfer(sfc_pkg::OP_READ, 6'h28);
		check("array data", 9'h000, rx_byte);
		xfer(8'hFF, 6'h10);
		check("bad active", 9'h000, seen_act);
		check("bad so", 9'h0FF, rx_byte);
		xfer(sfc_pkg::OP_SMALL_UNIT_WIPE, 6'h20);
		check("sector", 9'h000, sector_idx);
		check("block", 9'h000, block_idx);
		check("busy", 9'h001, busy);
		i = 0;
		while (busy !== 1'b0 && i < 80)
		begin
			@(posedge clk);
			#1 i++;
		end
		if (i == 80)
		begin
			n_mismatch++;
			final_report();
		end
		check("busy end", 9'h000, status[0]);
		// second reset, now in mode 3 with the clock idling high
		rst_n = 1'b0;
		clock_idle_polarity = 1'b1;
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		// the clock must stand at its high idle level before select falls
		repeat (4) @(posedge clk);
		#1;
		xfer(sfc_pkg::OP_WRITE_LATCH_SET, 6'h08);
		check("m3 done", 9'h001, seen_done);
		check("m3 latch", 9'h001, status[1]);
		xfer(sfc_pkg::OP_ID_READ, 6'h10);
		check("m3 id", sfc_pkg::ID_BYTE, rx_byte);
		final_report();
	end
endmodule
`default_nettype wire
